// file: logic/ebc_ctrl.sv
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
// Operation
// - seven chip-select spaces, 64 MB each
// - space 0 16-bit; others 8 or 16
// - wait states and idle gaps per space
// - normal code gives random access anywhere
// - page read only in spaces 0, 4
// - idle-after-write code sets post-write gap
// - read-then-write gaps use same encoding
// - read-read code zero gives no gap
// - endian 0 big; size 10 16-bit
// - boot mode 0 forces 16-bit, big-endian
// - strobe lead code delays strobe after select
// - strobe trail code holds select after strobe
// - wait code stretches strobe by cycles
// - ignore bit masks external wait input
// - burst pattern code selects page sequence; code ignores it, pages in linear order
// - page latency code sets later page waits
// - wait code sets first page access waits
// - boot 0 address pins, upper lines ports
// - upper address, write strobe start inputs
// - function code 01 selects memory pin use
// - page mode has zero lead, trail
module ebc_ctrl
   import ebc_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK_IN,
   input wire logic RST_B_IN,
   // ahb-lite slave
   input wire logic HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic HREADY_IN,
   output logic [31:0] HRDATA_OUT,
   output logic HREADYOUT_OUT,
   output logic HRESP_OUT,
   // boot straps
   input wire logic BOOT_STRAP_0_IN,
   input wire logic BOOT_STRAP_1_IN,
   // external memory
   output logic [6:0] CHIP_SELECT_N_OUT,
   output logic RD_N_OUT,
   output logic WRITE_STROBE_0_N_OUT,
   output logic WRITE_STROBE_0_OE_OUT,
   output logic [20:0] MEM_ADDR_OUT,
   output logic [4:0] MEM_ADDR_HI_OUT,
   output logic [4:0] MEM_ADDR_HI_OE_OUT,
   input wire logic [15:0] MEM_DATA_IN,
   output logic [15:0] MEM_DATA_OUT,
   output logic MEM_DATA_OE_OUT,
   input wire logic EXT_WAIT_N_IN
);
   logic [31:0] bus_ctrl [NUM_SPACES];
   logic [31:0] wait_ctrl [NUM_SPACES];
   logic [31:0] pin_func;
   logic boot_mode0, boot_caught, strap0, strap1;
   logic reg_wr_pend, rd_pend, wdata_pend;
   logic [31:0] reg_addr, rd_mux, wdata, rdata, rd_merge, wsrc;
   ebc_state_t state, next_state;
   logic [4:0] cnt, next_cnt, idle_need, lead, trail, wait_first, bw;
   logic [2:0] beat, next_beat, beats, cur_space, last_space, new_space;
   logic [25:0] cur_addr;
   logic cur_write, last_write, have_last, w16, little, page_mode;
   logic ignore_wait, wait_ok, ext_take, reg_take, done, active;
   logic [1:0] lane, off;
   logic [4:0] shift;
   logic [31:0] bc, wc, lbc;

   assign ext_take = HSEL_IN && HTRANS_IN[1] && HREADY_IN
                     && (HADDR_IN < EXT_LIMIT);
   assign reg_take = HSEL_IN && HTRANS_IN[1] && HREADY_IN
                     && (HADDR_IN >= EXT_LIMIT);
   assign new_space = HADDR_IN[SPACE_LSB +: 3];
   // fields of the space being accessed, and bus control of the last one
   always_comb begin
      bc = bus_ctrl[cur_space];
      wc = wait_ctrl[cur_space];
      lbc = bus_ctrl[last_space];
      // space 0 is always 16 bits wide
      w16 = (cur_space == PAGE_SPACE_A)
            || (bc[BSZ_LSB +: 2] == BSZ_16);
      // big endian unless little chosen and allowed
      little = bc[ENDIAN_BIT]
               && !(cur_space == PAGE_SPACE_A && boot_mode0);
      // page read only where the space supports it
      page_mode = (bc[TYPE_LSB +: 3] == TYPE_PAGE)
                  && (cur_space == PAGE_SPACE_A
                      || cur_space == PAGE_SPACE_B);
      // page mode cannot stretch the select
      lead = page_mode ? 5'h00 : {3'h0, wc[SW_LSB +: 2]};
      trail = page_mode ? 5'h00 : {3'h0, wc[HW_LSB +: 2]};
      bw = {3'h0, wc[BW_LSB +: 2]};
      // first access wait, live from the register
      wait_first = ebc_wait_cycles(wc[WR_LSB +: 4]);
      ignore_wait = wc[WM_BIT];
      wait_ok = ignore_wait || EXT_WAIT_N_IN;
      beats = w16 ? 3'h2 : 3'h4;
   end
   // idle gap owed before the new access
   always_comb begin
      idle_need = 5'h00;
      if (have_last && last_write)
         idle_need = ebc_idle_cycles(lbc[IWW_LSB +: 3]);
      else if (have_last && HWRITE_IN && new_space == last_space)
         idle_need = ebc_idle_cycles(lbc[IDLE_READ_THEN_WRITE_SAME_LSB +: 3]);
      else if (have_last && HWRITE_IN)
         idle_need = ebc_idle_cycles(lbc[IDLE_READ_THEN_WRITE_DIFF_LSB +: 3]);
      else if (have_last && new_space == last_space)
         idle_need = ebc_idle_cycles(lbc[IDLE_READ_THEN_READ_SAME_LSB +: 3]);
      else if (have_last)
         idle_need = ebc_idle_cycles(lbc[IDLE_READ_THEN_READ_DIFF_LSB +: 3]);
   end
   // access sequencer
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_beat = beat;
      case (state)
         ST_IDLE: begin
            if (ext_take) begin
               next_state = ST_GAP;
               next_cnt = idle_need;
               next_beat = 3'h0;
            end
         end
         ST_GAP: begin
            if (cnt != 5'h00) begin
               next_cnt = cnt - 5'h01;
            end else if (lead == 5'h00) begin
               next_state = ST_STROBE;
               next_cnt = wait_first;
            end else begin
               next_state = ST_SETUP;
               next_cnt = lead - 5'h01;
            end
         end
         ST_SETUP: begin
            if (cnt != 5'h00) begin
               next_cnt = cnt - 5'h01;
            end else begin
               next_state = ST_STROBE;
               next_cnt = wait_first;
            end
         end
         ST_STROBE: begin
            if (cnt != 5'h00) begin
               next_cnt = cnt - 5'h01;
            end else if (wait_ok) begin
               next_beat = beat + 3'h1;
               if (next_beat == beats && trail == 5'h00) begin
                  next_state = ST_IDLE;
               end else if (next_beat == beats) begin
                  next_state = ST_HOLD;
                  next_cnt = trail - 5'h01;
               end else if (page_mode && !cur_write) begin
                  // next page word, select kept low
                  next_cnt = bw;
               end else if (trail == 5'h00) begin
                  next_state = ST_GAP;
                  next_cnt = 5'h00;
               end else begin
                  next_state = ST_HOLD;
                  next_cnt = trail - 5'h01;
               end
            end
         end
         ST_HOLD: begin
            if (cnt != 5'h00) begin
               next_cnt = cnt - 5'h01;
            end else if (beat == beats) begin
               next_state = ST_IDLE;
            end else begin
               next_state = ST_GAP;
               next_cnt = 5'h00;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end
   assign done = (state != ST_IDLE) && (next_state == ST_IDLE);
   assign active = (next_state == ST_SETUP) || (next_state == ST_STROBE)
                   || (next_state == ST_HOLD);
   // byte lane of a beat and the data path
   always_comb begin
      if (!w16) lane = little ? beat[1:0] : 2'h3 - beat[1:0];
      else lane = little ? beat[1:0] : 2'h1 - beat[1:0];
      shift = w16 ? {lane[0], 4'h0} : {lane, 3'h0};
      off = w16 ? {next_beat[0], 1'b0} : next_beat[1:0];
      wsrc = wdata_pend ? HWDATA_IN : wdata;
      rd_merge = rdata | (({16'h0000, w16 ? MEM_DATA_IN
                           : {8'h00, MEM_DATA_IN[7:0]}}) << shift);
   end
   // sequencer state and current access
   always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         state <= ST_IDLE;
         cnt <= 5'h00;
         beat <= 3'h0;
         cur_space <= 3'h0;
         cur_addr <= 26'h0;
         cur_write <= 1'b0;
         wdata_pend <= 1'b0;
         wdata <= 32'h0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         beat <= next_beat;
         wdata_pend <= ext_take && HWRITE_IN;
         if (wdata_pend) wdata <= HWDATA_IN;
         if (ext_take) begin
            cur_space <= new_space;
            cur_addr <= HADDR_IN[25:0];
            cur_write <= HWRITE_IN;
         end
      end
   end
   // previous access for idle spacing
   always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         have_last <= 1'b0;
         last_write <= 1'b0;
         last_space <= 3'h0;
      end else if (done) begin
         have_last <= 1'b1;
         last_write <= cur_write;
         last_space <= cur_space;
      end
   end
   // read data assembly
   always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) rdata <= 32'h0;
      else if (ext_take) rdata <= 32'h0;
      else if (state == ST_STROBE && cnt == 5'h00 && wait_ok && !cur_write)
         rdata <= rd_merge;
   end
   // memory pins, all registered
   always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         CHIP_SELECT_N_OUT <= 7'h7f;
         RD_N_OUT <= 1'b1;
         WRITE_STROBE_0_N_OUT <= 1'b1;
         MEM_ADDR_OUT <= 21'h0;
         MEM_ADDR_HI_OUT <= 5'h00;
         MEM_DATA_OUT <= 16'h0000;
         MEM_DATA_OE_OUT <= 1'b0;
      end else begin
         CHIP_SELECT_N_OUT <= ~(active ? 7'h01 << cur_space : 7'h00);
         RD_N_OUT <= !(next_state == ST_STROBE && !cur_write);
         WRITE_STROBE_0_N_OUT <= !(next_state == ST_STROBE && cur_write);
         // low lines always carry the address
         MEM_ADDR_OUT <= {cur_addr[20:2], off};
         MEM_ADDR_HI_OUT <= cur_addr[25:21];
         MEM_DATA_OUT <= w16 ? 16'(wsrc >> shift)
                         : {8'h00, 8'(wsrc >> shift)};
         MEM_DATA_OE_OUT <= active && cur_write;
      end
   end

   // upper address pins stay ports until selected
   for (genvar i = 0; i < NUM_HI_ADDR; i++) begin : g_hi
      always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
         if (!RST_B_IN) MEM_ADDR_HI_OE_OUT[i] <= 1'b0;
         else MEM_ADDR_HI_OE_OUT[i] <= pin_func[2*i +: 2] == FN_ALT;
      end
   end
   // write strobe pin function
   always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) WRITE_STROBE_0_OE_OUT <= 1'b0;
      else WRITE_STROBE_0_OE_OUT <= pin_func[PIN_FN_WE_LSB +: 2] == FN_ALT;
   end

   // strap capture after reset release
   always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         boot_caught <= 1'b0;
         boot_mode0 <= 1'b1;
         strap0 <= 1'b0;
         strap1 <= 1'b0;
      end else if (!boot_caught) begin
         boot_caught <= 1'b1;
         boot_mode0 <= !BOOT_STRAP_0_IN && !BOOT_STRAP_1_IN;
         strap0 <= BOOT_STRAP_0_IN;
         strap1 <= BOOT_STRAP_1_IN;
      end
   end
   // register read decode
   always_comb begin
      rd_mux = 32'h0;
      for (int i = 0; i < NUM_SPACES; i++) begin
         if (reg_addr == REG_BUS_CTRL0 + REG_STEP * i) rd_mux = bus_ctrl[i];
         else if (reg_addr == REG_WAIT_CTRL0 + REG_STEP * i)
            rd_mux = wait_ctrl[i];
      end
      if (reg_addr == REG_PIN_FUNC) rd_mux = pin_func;
      else if (reg_addr == REG_STATUS) begin
         rd_mux[STAT_BOOT0_BIT] = boot_mode0;
         rd_mux[STAT_BUSY_BIT] = state != ST_IDLE;
         rd_mux[STAT_STRAP0_BIT] = strap0;
         rd_mux[STAT_STRAP1_BIT] = strap1;
      end
   end

   // ahb answer
   always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         HREADYOUT_OUT <= 1'b1;
         HRDATA_OUT <= 32'h0;
         HRESP_OUT <= 1'b0;
         reg_wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         reg_addr <= 32'h0;
      end else begin
         HRESP_OUT <= 1'b0;
         reg_wr_pend <= reg_take && HWRITE_IN;
         rd_pend <= reg_take && !HWRITE_IN;
         if (reg_take) reg_addr <= HADDR_IN;
         if (ext_take || (reg_take && !HWRITE_IN)) begin
            HREADYOUT_OUT <= 1'b0;
         end else if (rd_pend) begin
            HREADYOUT_OUT <= 1'b1;
            HRDATA_OUT <= rd_mux;
         end else if (done) begin
            HREADYOUT_OUT <= 1'b1;
            HRDATA_OUT <= (state == ST_STROBE && !cur_write) ? rd_merge
                          : rdata;
         end
      end
   end

   // configuration registers per space
   for (genvar s = 0; s < NUM_SPACES; s++) begin : g_sp
      always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
         if (!RST_B_IN) begin
            bus_ctrl[s] <= BUS_CTRL_RST;
            wait_ctrl[s] <= WAIT_CTRL_RST;
         end else if (reg_wr_pend) begin
            if (reg_addr == REG_BUS_CTRL0 + REG_STEP * s)
               bus_ctrl[s] <= HWDATA_IN & BUS_CTRL_MASK;
            if (reg_addr == REG_WAIT_CTRL0 + REG_STEP * s)
               wait_ctrl[s] <= HWDATA_IN & WAIT_CTRL_MASK;
         end
      end
   end

   // pin function register
   always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) pin_func <= 32'h0;
      else if (reg_wr_pend && reg_addr == REG_PIN_FUNC)
         pin_func <= HWDATA_IN & PIN_FUNC_MASK;
   end

   // assertion helpers: strobe and lead lengths
   logic [5:0] strb_len, lead_len;
   always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         strb_len <= 6'h0;
         lead_len <= 6'h0;
      end else begin
         strb_len <= !RD_N_OUT ? strb_len + 6'h1 : 6'h0;
         lead_len <= (CHIP_SELECT_N_OUT != 7'h7f && RD_N_OUT)
                     ? lead_len + 6'h1 : 6'h0;
      end
   end

   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (!RST_B_IN);

   cs_one_hot_a: assert property ($onehot0(~CHIP_SELECT_N_OUT))
      else $error("more than one chip select low");
   strobe_excl_a: assert property (!(!RD_N_OUT && !WRITE_STROBE_0_N_OUT)
      && (RD_N_OUT || CHIP_SELECT_N_OUT != 7'h7f))
      else $error("strobe without select or both strobes low");
   ext_done_a: assert property (ext_take
      |=> !HREADYOUT_OUT ##[1:400] HREADYOUT_OUT)
      else $error("external access did not finish");
   strobe_len_a: assert property ($rose(RD_N_OUT) && !page_mode
      && ignore_wait |-> strb_len == 6'(wait_first) + 6'h1)
      else $error("read strobe length differs from wait setting");
   lead_len_a: assert property ($fell(RD_N_OUT) && beat == 3'h0
      |-> lead_len == 6'(lead))
      else $error("select to strobe delay wrong");
   page_no_setup_a: assert property (page_mode
      |-> state != ST_SETUP && state != ST_HOLD)
      else $error("page mode stretched the select");
   space0_wide_a: assert property (cur_space == PAGE_SPACE_A
      |-> w16 && !(boot_mode0 && little))
      else $error("space 0 not 16-bit big endian");
   pin_fn_a: assert property (MEM_ADDR_HI_OE_OUT[0]
      |-> $past(pin_func[1:0]) == FN_ALT)
      else $error("address 21 driven without function select");
   wait_mask_a: assert property (state == ST_STROBE && cnt == 5'h00
      && ignore_wait && !page_mode && !EXT_WAIT_N_IN
      |=> state != ST_STROBE || beat != $past(beat))
      else $error("external wait honoured while masked");
endmodule

// file: logic/ebc_pkg.sv
package ebc_pkg;
   localparam int NUM_SPACES = 7;
   localparam int SPACE_LSB = 26;
   localparam logic [31:0] EXT_LIMIT = 32'h1c000000;
   // register byte addresses
   localparam logic [31:0] REG_BUS_CTRL0 = 32'hfffc0004;
   localparam logic [31:0] REG_WAIT_CTRL0 = 32'hfffc0028;
   localparam logic [31:0] REG_PIN_FUNC = 32'hfffc0100;
   localparam logic [31:0] REG_STATUS = 32'hfffc0104;
   localparam logic [31:0] REG_STEP = 32'h00000004;
   // bus control fields
   localparam int IWW_LSB = 28;
   localparam int IDLE_READ_THEN_WRITE_DIFF_LSB = 25;
   localparam int IDLE_READ_THEN_WRITE_SAME_LSB = 22;
   localparam int IDLE_READ_THEN_READ_DIFF_LSB = 19;
   localparam int IDLE_READ_THEN_READ_SAME_LSB = 16;
   localparam int TYPE_LSB = 12;
   localparam int ENDIAN_BIT = 11;
   localparam int BSZ_LSB = 9;
   localparam logic [31:0] BUS_CTRL_MASK = 32'h7fff7e00;
   localparam logic [31:0] BUS_CTRL_RST = 32'h00000400;
   // wait control fields
   localparam int BST_LSB = 20;
   localparam int BW_LSB = 16;
   localparam int SW_LSB = 11;
   localparam int WR_LSB = 7;
   localparam int WM_BIT = 6;
   localparam int HW_LSB = 0;
   localparam logic [31:0] WAIT_CTRL_MASK = 32'h00331fc3;
   localparam logic [31:0] WAIT_CTRL_RST = 32'h00000500;
   // codes
   localparam logic [2:0] TYPE_NORMAL = 3'h0;
   localparam logic [2:0] TYPE_PAGE = 3'h1;
   localparam logic [1:0] BSZ_16 = 2'h2;
   localparam logic [2:0] PAGE_SPACE_A = 3'h0;
   localparam logic [2:0] PAGE_SPACE_B = 3'h4;
   localparam logic [1:0] FN_ALT = 2'h1;
   // pin function and status layout
   localparam int NUM_HI_ADDR = 5;
   localparam int PIN_FN_WE_LSB = 10;
   localparam logic [31:0] PIN_FUNC_MASK = 32'h00000fff;
   localparam int STAT_BOOT0_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_STRAP0_BIT = 2;
   localparam int STAT_STRAP1_BIT = 3;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_GAP = 3'h1,
      ST_SETUP = 3'h3,
      ST_STROBE = 3'h2,
      ST_HOLD = 3'h6
   } ebc_state_t;
   // access wait code to cycles
   function automatic logic [4:0] ebc_wait_cycles(input logic [3:0] code);
      if (code <= 4'h6) return {1'b0, code};
      else if (code == 4'h7) return 5'h08;
      else return {code[3:0], 1'b0} - 5'h06;
   endfunction
   // idle code to cycles
   function automatic logic [4:0] ebc_idle_cycles(input logic [2:0] code);
      if (code <= 3'h2) return {2'h0, code};
      else return {1'b0, code, 1'b0} - 5'h02;
   endfunction
endpackage

// file: test/ebc_flash_model.sv
`timescale 1ns/1ps
module ebc_flash_model (
   // flash control
   input wire logic cs_n_in,
   input wire logic oe_n_in,
   input wire logic we_n_in,
   // address and data
   input wire logic [20:0] addr_in,
   input wire logic [15:0] data_in,
   output logic [15:0] data_out
);
   logic [15:0] mem [0:63];
   logic [15:0] last = 16'h0000;
   logic [5:0] waddr = 6'h00;
   logic armed = 1'b0;

   // array starts cleared so early reads are defined
   initial begin
      for (int i = 0; i < 64; i++) begin
         mem[i] = 16'h0000;
      end
   end

   // address caught as the strobe falls under select, data as it rises
   always @(negedge we_n_in) begin
      #1;
      armed = !cs_n_in;
      waddr = addr_in[6:1];
   end
   always @(posedge we_n_in) begin
      if (armed) mem[waddr] = data_in;
      armed = 1'b0;
   end

   // async page read; inverse of the last word once released
   assign data_out = (!cs_n_in && !oe_n_in) ? mem[addr_in[6:1]] : ~last;

   // remember the word seen as output enable goes away
   always @(posedge oe_n_in) begin
      last = mem[addr_in[6:1]];
   end
endmodule

// file: test/tb_ebc_ctrl.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_ebc_ctrl;
   import ebc_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h00000000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h00000000;
   logic strap0 = 1'b0; // both straps low pick boot mode 0
   logic strap1 = 1'b0;
   logic ext_wait_n = 1'b1;
   logic hready, hresp, rd_n, we_n, we_oe, data_oe, we_w, hr_n, rd_prev;
   logic [31:0] hrdata, hrd_n, q, d, a;
   logic [31:0] rs = 32'h59716b6a;
   logic [6:0] cs_n, cs_seen;
   logic [20:0] maddr;
   logic [4:0] ahi, ahi_oe;
   logic [15:0] mdin, mdout;
   int fails = 0;
   int checks = 0;
   int rd_low, cs0_low, we_low, rd_falls, n, n_rr;

   ebc_ctrl i_ebc_ctrl (.REF_CLK_IN(ref_clk), .RST_B_IN(rst_b),
      .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
      .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
      .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
      .HRESP_OUT(hresp), .BOOT_STRAP_0_IN(strap0),
      .BOOT_STRAP_1_IN(strap1), .CHIP_SELECT_N_OUT(cs_n), .RD_N_OUT(rd_n),
      .WRITE_STROBE_0_N_OUT(we_n), .WRITE_STROBE_0_OE_OUT(we_oe),
      .MEM_ADDR_OUT(maddr), .MEM_ADDR_HI_OUT(ahi),
      .MEM_ADDR_HI_OE_OUT(ahi_oe), .MEM_DATA_IN(mdin),
      .MEM_DATA_OUT(mdout), .MEM_DATA_OE_OUT(data_oe),
      .EXT_WAIT_N_IN(ext_wait_n));

   ebc_flash_model i_ebc_flash_model (.cs_n_in(cs_n[0]), .oe_n_in(rd_n),
      .we_n_in(we_w), .addr_in(maddr), .data_in(mdout), .data_out(mdin));

   // pulled up while the pin is still a port input
   assign we_w = we_oe ? we_n : 1'b1;

   // clock
   always #25 ref_clk = ~ref_clk;

   // settled samples and strobe counters, taken mid-cycle
   always @(negedge ref_clk) begin
      hr_n = hready;
      hrd_n = hrdata;
      if (!rd_n) rd_low++;
      if (!cs_n[0]) cs0_low++;
      if (!we_w) we_low++;
      if (rd_prev && !rd_n) rd_falls++;
      rd_prev = rd_n;
      cs_seen = cs_seen | ~cs_n;
   end

   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction

   function automatic int beat_cyc(int lead, int wt, int trail, int beats);
      return beats * (lead + wt + 1 + trail);
   endfunction

   // one single ahb-lite word transfer; n counts data-phase waits
   task automatic ahb(input logic wr, input logic [31:0] ad, dd);
      int k;
      k = 0;
      n = 0;
      rd_low = 0;
      cs0_low = 0;
      we_low = 0;
      rd_falls = 0;
      cs_seen = 7'h00;
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= ad;
      hwrite <= wr;
      @(posedge ref_clk);
      while (hr_n !== 1'b1 && k < 900) begin
         k++;
         @(posedge ref_clk);
      end
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= dd;
      @(posedge ref_clk);
      while (hr_n !== 1'b1 && n < 900) begin
         n++;
         @(posedge ref_clk);
      end
      if (k >= 900 || n >= 900) fails++; // bus limit ran out
      q = hrd_n;
   endtask

   task automatic chk(input logic [31:0] ad, ex);
      ahb(1'b0, ad, 32'h00000000);
      `CHK(q, ex)
   endtask

   task automatic end_of_test();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // watchdog
   initial begin
      #3000000;
      fails++;
      end_of_test();
   end

   // main sequence
   initial begin
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk(REG_STATUS, 32'h00000001);
      chk(REG_BUS_CTRL0, BUS_CTRL_RST);
      chk(REG_WAIT_CTRL0, WAIT_CTRL_RST);
      `CHK(ahi_oe, 5'h00)
      `CHK(we_oe, 1'b0)
      $display("test reset done");
      ahb(1'b1, REG_WAIT_CTRL0, 32'h00000b41);
      ahb(1'b1, REG_BUS_CTRL0, 32'h12400400);
      ahb(1'b1, REG_PIN_FUNC, 32'h00000401);
      ahb(1'b1, 32'hfffc0200, 32'hffffffff);
      chk(REG_WAIT_CTRL0, 32'h00000b41);
      chk(REG_BUS_CTRL0, 32'h12400400);
      chk(32'hfffc0200, 32'h00000000);
      `CHK(ahi_oe, 5'h01)
      `CHK(we_oe, 1'b1)
      $display("test config done");
      ext_wait_n <= 1'b0; // held asserted, masked by the ignore bit
      for (int i = 0; i < 4; i++) begin
         d = (i == 0) ? 32'hffff0000 : xs();
         a = xs() & 32'h0000007c;
         ahb(1'b0, a, 32'h00000000);
         ahb(1'b0, a, 32'h00000000);
         n_rr = n;
         ahb(1'b1, a, d);
         `CHK(n - n_rr, 1)
         `CHK(we_low, beat_cyc(0, 6, 0, 2))
         `CHK(i_ebc_flash_model.mem[a[6:1]], d[31:16])
         `CHK(i_ebc_flash_model.mem[a[6:1] + 6'h01], d[15:0])
         ahb(1'b0, a, 32'h00000000);
         `CHK(n - n_rr, 1)
         `CHK(q, d)
         `CHK(rd_low, beat_cyc(0, 6, 0, 2))
         `CHK(cs0_low, beat_cyc(1, 6, 1, 2))
      end
      $display("test normal done");
      ext_wait_n <= 1'b1; // other spaces honour the wait input
      ahb(1'b1, REG_BUS_CTRL0, 32'h12400a00);
      ahb(1'b0, a, 32'h00000000);
      `CHK(rd_falls, 2)
      `CHK(q, d)
      ahb(1'b1, REG_BUS_CTRL0 + REG_STEP, 32'h00001200);
      for (int s = 1; s < 7; s++) begin
         ahb(1'b0, 32'(s) << 26, 32'h00000000);
         `CHK(cs_seen, 7'h01 << s)
         if (s == 1) `CHK(rd_falls, 4)
      end
      $display("test spaces done");
      ahb(1'b1, REG_WAIT_CTRL0, 32'h002203c0); // before the type
      ahb(1'b1, REG_BUS_CTRL0, 32'h24801400);
      chk(REG_WAIT_CTRL0, 32'h002203c0);
      ahb(1'b0, a, 32'h00000000);
      ahb(1'b0, a, 32'h00000000);
      n_rr = n;
      `CHK(rd_low, beat_cyc(0, 8, 0, 1) + beat_cyc(0, 2, 0, 1))
      `CHK(cs0_low, rd_low)
      `CHK(q, d)
      d = xs();
      ahb(1'b1, a, d);
      ahb(1'b0, a, 32'h00000000);
      `CHK(n - n_rr, 2)
      `CHK(q, d)
      $display("test page done");
      // mid-run reset with one strap high leaves boot mode 0
      rst_b <= 1'b0;
      strap0 <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk(REG_STATUS, 32'h00000004);
      ahb(1'b1, REG_BUS_CTRL0, 32'h00000800);
      ahb(1'b0, a, 32'h00000000);
      `CHK(q, {d[15:0], d[31:16]})
      `CHK(rd_falls, 2)
      $display("test boot mode done");
      end_of_test();
   end
endmodule
